// ==== logic/tife_pkg.sv ====
package tife_pkg;

  // ---------------------------------------------------------------------------
  // register map (word addresses on the plain port)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_RES    = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_PCNT   = 4'h3;
  localparam logic [3:0] ADDR_ROTS   = 4'h4;

  // ctrl field positions
  localparam int CTRL_WIDTH_LSB = 0;
  localparam int CTRL_ENC_EN    = 4;
  localparam int CTRL_USE_IDX   = 5;
  localparam int CTRL_MULTI     = 6;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ       = 200;
  localparam int US_STEP       = 100;
  localparam int OFF_US        = 500;
  localparam int STEP_CYC      = US_STEP * CLK_MHZ;
  localparam int OFF_CYC       = OFF_US * CLK_MHZ;
  localparam int CNT_W         = 17;

  // filter width codes: 0..4 = 100..500 us
  localparam logic [2:0] WIDTH_DEF = 3'h0;
  localparam logic [2:0] WIDTH_MAX = 3'h4;
  localparam logic [15:0] RES_DEF  = 16'h0001;

  typedef struct packed {
    logic       multi_line;
    logic       use_index;
    logic       enc_en;
    logic [2:0] width_code;
  } tife_cfg_t;

  typedef struct packed {
    logic phase_a;
    logic index_z;
  } tife_enc_t;

endpackage

// ==== logic/tife_filter.sv ====
`timescale 1ns/100ps
module tife_filter
  import tife_pkg::*;
#(
  parameter int ON_MAX  = 5 * STEP_CYC,
  parameter int OFF_LEN = OFF_CYC
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // raw input and on-length in cycles
  input  wire logic             raw_in,
  input  wire logic [CNT_W-1:0] on_len,
  // filtered level
  output logic                  level_ff
);

  initial begin
    if (ON_MAX >= (1 << CNT_W) || OFF_LEN >= (1 << CNT_W)) $error("count too wide");
  end

  logic [CNT_W-1:0] run_ff;

  // ---------------------------------------------------------------------------
  // run length of input differing from output
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || raw_in == level_ff) begin
      run_ff <= '0;
    end else begin
      run_ff <= run_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_ff <= 1'b0;
    end else if (!level_ff && raw_in && run_ff + 1'b1 >= on_len) begin
      level_ff <= 1'b1;
    end else if (level_ff && !raw_in && run_ff + 1'b1 >= CNT_W'(OFF_LEN)) begin
      level_ff <= 1'b0;
    end
  end

  a_on_delay: assert property (@(posedge clk) disable iff (rst)
    $rose(level_ff) |-> $past(raw_in) && $past(run_ff) + 1'b1 >= $past(on_len))
    else $error("on without high input");
  a_off_delay: assert property (@(posedge clk) disable iff (rst)
    $fell(level_ff) |-> $past(!raw_in) && $past(run_ff) == CNT_W'(OFF_LEN - 1))
    else $error("off without low input");

endmodule // tife_filter

// ==== logic/tife_top.sv ====
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
module tife_top
  import tife_pkg::*;
#(
  parameter int LINES = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata_ff,
  // trigger inputs and filtered levels
  input  wire logic [LINES-1:0] trig_raw,
  output logic      [LINES-1:0] trig_on_ff,
  // encoder
  input  wire tife_enc_t        enc_in,
  output logic                  rot_pulse_ff
);

  initial begin
    if (LINES < 1 || LINES > 16) $error("LINES out of range");
  end

  function automatic logic [CNT_W-1:0] width_cycles(input logic [2:0] code);
    width_cycles = CNT_W'((int'(code) + 1) * STEP_CYC);
  endfunction

  tife_cfg_t        cfg_ff;
  logic [2:0]       width_ff [LINES];
  logic [15:0]      res_ff;
  logic [15:0]      pcnt_ff;
  logic [15:0]      rots_ff;
  logic             a_dly_ff;
  logic             z_dly_ff;
  logic [LINES-1:0] trig_lvl;

  // ---------------------------------------------------------------------------
  // configuration writes
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_ff <= '{multi_line: 1'b0, use_index: 1'b0, enc_en: 1'b0, width_code: WIDTH_DEF};
    end else if (reg_wr && reg_addr == ADDR_CTRL) begin
      cfg_ff.enc_en     <= reg_wdata[CTRL_ENC_EN];
      cfg_ff.use_index  <= reg_wdata[CTRL_USE_IDX];
      cfg_ff.multi_line <= reg_wdata[CTRL_MULTI];
      if (reg_wdata[CTRL_WIDTH_LSB +: 3] <= WIDTH_MAX) begin
        cfg_ff.width_code <= reg_wdata[CTRL_WIDTH_LSB +: 3];
      end
    end
  end

  // per-line widths at word ADDR_CTRL + 8 + line, except line 0, which takes the width field at ADDR_CTRL
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      always_ff @(posedge clk) begin
        if (rst) begin
          width_ff[g] <= WIDTH_DEF;
        end else if (g == 0 && reg_wr && reg_addr == ADDR_CTRL && reg_wdata[2:0] <= WIDTH_MAX) begin
          width_ff[g] <= reg_wdata[2:0];
        end else if (g != 0 && reg_wr && reg_addr == 4'(8 + g) && reg_wdata[2:0] <= WIDTH_MAX) begin
          width_ff[g] <= reg_wdata[2:0];
        end
      end

      tife_filter u_filt (
        .clk      (clk),
        .rst      (rst),
        .raw_in   (trig_raw[g]),
        .on_len   (width_cycles(cfg_ff.multi_line ? width_ff[0] : width_ff[g])),
        .level_ff (trig_lvl[g])
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      trig_on_ff <= '0;
    end else begin
      trig_on_ff <= trig_lvl;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      res_ff <= RES_DEF;
    end else if (reg_wr && reg_addr == ADDR_RES && reg_wdata[15:0] != 16'h0000) begin
      res_ff <= reg_wdata[15:0];
    end
  end

  // ---------------------------------------------------------------------------
  // encoder rotation detection
  // ---------------------------------------------------------------------------
  logic a_rise;
  logic z_rise;
  logic rot_hit;
  assign a_rise  = enc_in.phase_a && !a_dly_ff;
  assign z_rise  = enc_in.index_z && !z_dly_ff;
  assign rot_hit = cfg_ff.enc_en && (cfg_ff.use_index ? z_rise
                                                      : a_rise && pcnt_ff + 16'h0001 >= res_ff);

  always_ff @(posedge clk) begin
    if (rst) begin
      a_dly_ff <= 1'b0;
      z_dly_ff <= 1'b0;
    end else begin
      a_dly_ff <= enc_in.phase_a;
      z_dly_ff <= enc_in.index_z;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !cfg_ff.enc_en) begin
      pcnt_ff <= '0;
    end else if (rot_hit) begin
      pcnt_ff <= '0;
    end else if (a_rise) begin
      pcnt_ff <= pcnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rot_pulse_ff <= 1'b0;
      rots_ff      <= '0;
    end else begin
      rot_pulse_ff <= rot_hit;
      if (rot_hit) begin
        rots_ff <= rots_ff + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || !reg_rd) begin
      reg_rdata_ff <= '0;
    end else begin
      case (reg_addr)
        ADDR_CTRL:   reg_rdata_ff <= 32'({cfg_ff.multi_line, cfg_ff.use_index, cfg_ff.enc_en, 1'b0,
                                           cfg_ff.width_code});
        ADDR_RES:    reg_rdata_ff <= 32'(res_ff);
        ADDR_STATUS: reg_rdata_ff <= 32'(trig_on_ff);
        ADDR_PCNT:   reg_rdata_ff <= 32'(pcnt_ff);
        ADDR_ROTS:   reg_rdata_ff <= 32'(rots_ff);
        default:     reg_rdata_ff <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_enc_gated: assert property (@(posedge clk) disable iff (rst)
    !cfg_ff.enc_en |=> !rot_pulse_ff)
    else $error("rotation while encoder disabled");
  a_res_nonzero: assert property (@(posedge clk) disable iff (rst)
    res_ff != 16'h0000)
    else $error("resolution zero");
  a_idx_rot: assert property (@(posedge clk) disable iff (rst)
    cfg_ff.enc_en && cfg_ff.use_index && z_rise |=> rot_pulse_ff)
    else $error("index pulse missed");
  a_cnt_rot: assert property (@(posedge clk) disable iff (rst)
    cfg_ff.enc_en && !cfg_ff.use_index && a_rise && pcnt_ff + 16'h0001 == res_ff |=> rot_pulse_ff)
    else $error("count rotation missed");
  a_cnt_clear: assert property (@(posedge clk) disable iff (rst)
    rot_hit |=> pcnt_ff == 16'h0000)
    else $error("counter not cleared");
  a_width_range: assert property (@(posedge clk) disable iff (rst)
    cfg_ff.width_code <= WIDTH_MAX)
    else $error("width code out of range");

endmodule // tife_top

// ==== tb/tife_enc_model.sv ====
`timescale 1ns/100ps
// -----------------------------------------------------------------------------
// encoder model: one phase a or index pulse per request
// -----------------------------------------------------------------------------
module tife_enc_model
  import tife_pkg::*;
(
  // clock
  input  wire logic clk,
  // request
  input  wire logic step,
  input  wire logic idx,
  // encoder lines
  output tife_enc_t enc
);
  logic [2:0] cnt_ff = 3'h0;
  logic       idx_ff = 1'h0;

  always_ff @(posedge clk) begin
    if (step) begin
      cnt_ff <= 3'h4;
      idx_ff <= idx;
    end else if (cnt_ff != 3'h0) begin
      cnt_ff <= cnt_ff - 3'h1;
    end
  end

  // two cycles high, two low, so every rise is seen
  assign enc.phase_a = (cnt_ff > 3'h2) && !idx_ff;
  assign enc.index_z = (cnt_ff > 3'h2) && idx_ff;
endmodule // tife_enc_model

// ==== tb/tb_trigger_input_filter_encoder.sv ====
`timescale 1ns/100ps
module tb_trigger_input_filter_encoder
  import tife_pkg::*;
;
  logic        clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic        step = 1'h0, idx = 1'h0, en_m = 1'h0, idx_m = 1'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_ff;
  logic [1:0]  trig_raw = 2'h0, trig_on_ff;
  logic        rot_pulse_ff;
  tife_enc_t   enc;
  integer      miscompares = 0, n_tests = 0, seed = 45;
  integer      rots_m = 0, pcnt_m = 0, rot_seen = 0, res = 1, i;

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (!rst && rot_pulse_ff === 1'h1) rot_seen = rot_seen + 1;
  end

  tife_top #(.LINES(2)) uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .trig_raw(trig_raw), .trig_on_ff(trig_on_ff), .enc_in(enc),
    .rot_pulse_ff(rot_pulse_ff));
  tife_enc_model enc_m (.clk(clk), .step(step), .idx(idx), .enc(enc));

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata_ff, exp);
  endtask

  // one encoder pulse, then the model follows
  task automatic pulse(input logic z);
    @(posedge clk);
    step <= 1'h1;
    idx  <= z;
    @(posedge clk);
    step <= 1'h0;
    repeat (8) @(posedge clk);
    if (en_m && z && idx_m) begin
      rots_m++;
      pcnt_m = 0;
    end else if (en_m && !z) begin
      pcnt_m++;
      if (!idx_m && pcnt_m == res) begin
        rots_m++;
        pcnt_m = 0;
      end
    end
  endtask

  task automatic wait_chk(input integer n, input logic [1:0] exp);
    repeat (n) @(posedge clk);
    #1 chk(trig_on_ff, exp);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #1_500_000;
    miscompares++;
    end_of_test();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_RES, 32'h1);
    rd(4'hF, 32'h0);
    for (i = 0; i < 3; i++) pulse(1'h0);
    rd(ADDR_PCNT, 32'h0);
    wr(ADDR_RES, 32'h0);
    wr(ADDR_CTRL, 32'h5);
    rd(ADDR_RES, 32'h1);
    rd(ADDR_CTRL, 32'h0);
    wr(ADDR_RES, 32'hFFFF);
    rd(ADDR_RES, 32'hFFFF);
    res = 2 + {$random(seed)} % 5;
    wr(ADDR_RES, res[31:0]);
    wr(ADDR_CTRL, 32'h10);
    en_m = 1'h1;
    for (i = 0; i <= res; i++) pulse(1'h0);
    rd(ADDR_PCNT, pcnt_m[31:0]);
    rd(ADDR_ROTS, rots_m[31:0]);
    wr(ADDR_CTRL, 32'h30);
    idx_m = 1'h1;
    pulse(1'h0);
    pulse(1'h1);
    rd(ADDR_PCNT, pcnt_m[31:0]);
    rd(ADDR_ROTS, rots_m[31:0]);
    chk(rot_seen[31:0], rots_m[31:0]);
    // line 1 asks for 500 us, multi-line forces the 100 us of line 0
    wr(ADDR_CTRL, 32'h70);
    wr(4'h9, 32'h4);
    @(posedge clk);
    trig_raw <= 2'h1;
    repeat (1000) @(posedge clk);
    trig_raw <= 2'h0;
    @(posedge clk);
    trig_raw <= 2'h3;
    wait_chk(19996, 2'h0);
    wait_chk(6, 2'h3);
    @(posedge clk);
    trig_raw <= 2'h0;
    wait_chk(99996, 2'h3);
    wait_chk(6, 2'h0);
    end_of_test();
  end
endmodule // tb_trigger_input_filter_encoder
